//--- hcc_pkg.sv
// Constants, types and state codes for the histogram counter command block
// What this block does
// - Config command bit 6 picks 32/256 bins for pair 0, bit 7 pair 1.
// - Config argument bits 8-9 set the accumulation page of pair 0.
// - Config argument bits 10-11 set the read-out page of pair 0.
// - Config argument bits 12-13 set the accumulation page of pair 1.
// - Config argument bits 14-15 set the read-out page of pair 1.
// - Command bits 6-7 of init and read commands select the channel.
// - Short read sends and clears 32 counters, top first, three bytes each, then the echo.
// - Long read sends and clears 256 counters, top first, then the echo.
package hcc_pkg;

  // Opcode bits; command bit k is byte bit k
  localparam logic [5:0] CFG_OP   = 6'h05;
  localparam logic [4:0] INIT_OP  = 5'h15;
  localparam logic [5:0] RD32_OP  = 6'h0D;
  localparam logic [5:0] RD256_OP = 6'h2D;

  // Field positions in the command byte
  localparam int MODE0_BIT = 6;
  localparam int MODE1_BIT = 7;
  localparam int FILL_BIT  = 5;
  localparam int CHAN_LSB  = 6;

  // Counter counts and byte layout
  localparam logic [7:0] SHORT_LAST = 8'h1F;
  localparam logic [7:0] LONG_LAST  = 8'hFF;
  localparam logic [1:0] BYTE_LAST  = 2'h2;
  localparam logic [4:0] BYTE_BASE  = 5'h08;
  localparam int         MEM_WORDS  = 4096;

  typedef struct packed {
    logic       mode_pair1;
    logic       mode_pair0;
    logic [1:0] read_pg1;
    logic [1:0] act_pg1;
    logic [1:0] read_pg0;
    logic [1:0] act_pg0;
  } hcc_cfg_t;

  localparam hcc_cfg_t CFG_RESET = 10'h000;

  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic [7:0] bin;
  } hcc_evt_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ARG  = 5'h02,
    ST_INIT = 5'h04,
    ST_RD   = 5'h08,
    ST_ECHO = 5'h10
  } hcc_state_t;

endpackage

//--- hcc_core.sv
// Histogram counter command decoder, counter banks and byte-serial read-out
module hcc_core (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire logic [7:0]        cmd_byte,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [7:0]             rsp_byte,
  input  wire logic              rsp_ready,
  input  wire hcc_pkg::hcc_evt_t evt,
  output hcc_pkg::hcc_cfg_t      cfg,
  output logic                   busy,
  output logic                   evt_drop
);

  hcc_pkg::hcc_state_t state;
  hcc_pkg::hcc_state_t next_state;
  logic [7:0]          cmd_hold;
  logic [7:0]          idx;
  logic [1:0]          byte_sel;
  logic [31:0]         mem [0:hcc_pkg::MEM_WORDS-1];
  logic                take;
  logic                slot_free;
  logic                last_byte;
  logic [1:0]          chan;
  logic [1:0]          rpg;
  logic [11:0]         rd_addr;
  logic [31:0]         rd_word;
  logic [31:0]         pattern;
  logic                eng_wr;
  logic                wr_en;
  logic [11:0]         wr_addr;
  logic [31:0]         wr_data;
  logic [11:0]         evt_addr;

  // Read-out page of the pair that owns a channel
  function automatic logic [1:0] read_page(input hcc_pkg::hcc_cfg_t c,
                                           input logic [1:0] ch);
    return ch[1] ? c.read_pg1 : c.read_pg0;
  endfunction

  // Bank address: channel, page, counter
  function automatic logic [11:0] ctr_addr(input logic [1:0] ch,
                                           input logic [1:0] pg,
                                           input logic [7:0] bin);
    return {ch, pg, bin};
  endfunction

  // Handshake terms and read-out address
  assign take      = cmd_valid && cmd_ready;
  assign slot_free = !rsp_valid || rsp_ready;
  assign last_byte = (byte_sel == hcc_pkg::BYTE_LAST);
  assign chan      = cmd_hold[hcc_pkg::CHAN_LSB +: 2];
  assign rpg       = read_page(cfg, chan);
  assign rd_addr   = ctr_addr(chan, rpg, idx);
  assign rd_word   = mem[rd_addr];
  assign pattern   = {12'h000, chan, rpg, idx, 8'h00};

  // Next state of the command sequencer
  always_comb begin
    next_state = state;
    case (state)
      hcc_pkg::ST_IDLE: begin
        if (take) begin
          if (cmd_byte[5:0] == hcc_pkg::CFG_OP) begin
            next_state = hcc_pkg::ST_ARG;
          end else if (cmd_byte[4:0] == hcc_pkg::INIT_OP) begin
            next_state = hcc_pkg::ST_INIT;
          end else if (cmd_byte[5:0] == hcc_pkg::RD32_OP ||
                       cmd_byte[5:0] == hcc_pkg::RD256_OP) begin
            next_state = hcc_pkg::ST_RD;
          end
        end
      end
      hcc_pkg::ST_ARG: begin
        if (take) begin
          next_state = hcc_pkg::ST_ECHO;
        end
      end
      hcc_pkg::ST_INIT: begin
        if (idx == 8'h00) begin
          next_state = hcc_pkg::ST_ECHO;
        end
      end
      hcc_pkg::ST_RD: begin
        if (slot_free && last_byte && idx == 8'h00) begin
          next_state = hcc_pkg::ST_ECHO;
        end
      end
      hcc_pkg::ST_ECHO: begin
        if (slot_free) begin
          next_state = hcc_pkg::ST_IDLE;
        end
      end
      default: next_state = hcc_pkg::ST_IDLE;
    endcase
  end

  // State register and registered handshake outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state     <= hcc_pkg::ST_IDLE;
      cmd_ready <= 1'b0;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      cmd_ready <= next_state == hcc_pkg::ST_IDLE ||
                   next_state == hcc_pkg::ST_ARG;
      busy      <= next_state != hcc_pkg::ST_IDLE;
    end
  end

  // Command latch; unknown opcodes are taken and latched too, but start nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_hold <= 8'h00;
    end else if (state == hcc_pkg::ST_IDLE && take) begin
      cmd_hold <= cmd_byte;
    end
  end

  // Counter index counts down so the highest counter goes out first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx <= 8'h00;
    end else if (state == hcc_pkg::ST_IDLE && take) begin
      if (cmd_byte[5:0] == hcc_pkg::RD32_OP) begin
        idx <= hcc_pkg::SHORT_LAST;
      end else begin
        idx <= hcc_pkg::LONG_LAST;
      end
    end else if (state == hcc_pkg::ST_INIT && idx != 8'h00) begin
      idx <= idx - 8'h01;
    end else if (state == hcc_pkg::ST_RD && slot_free && last_byte &&
                 idx != 8'h00) begin
      idx <= idx - 8'h01;
    end
  end

  // Byte lane within a counter: bits 8-15, then 16-23, then 24-31
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byte_sel <= 2'h0;
    end else if (state != hcc_pkg::ST_RD) begin
      byte_sel <= 2'h0;
    end else if (slot_free) begin
      byte_sel <= last_byte ? 2'h0 : byte_sel + 2'h1;
    end
  end

  // Response register holds each byte until the host takes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_byte  <= 8'h00;
    end else if (state == hcc_pkg::ST_RD && slot_free) begin
      rsp_valid <= 1'b1;
      rsp_byte  <= rd_word[{byte_sel, 3'h0} + hcc_pkg::BYTE_BASE +: 8];
    end else if (state == hcc_pkg::ST_ECHO && slot_free) begin
      rsp_valid <= 1'b1;
      rsp_byte  <= cmd_hold;
    end else if (rsp_ready) begin
      rsp_valid <= 1'b0;
    end
  end

  // Mode bits come from the command byte, pages from the argument
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= hcc_pkg::CFG_RESET;
    end else if (state == hcc_pkg::ST_ARG && take) begin
      cfg.mode_pair0 <= cmd_hold[hcc_pkg::MODE0_BIT];
      cfg.mode_pair1 <= cmd_hold[hcc_pkg::MODE1_BIT];
      cfg.act_pg0    <= cmd_byte[1:0];
      cfg.read_pg0   <= cmd_byte[3:2];
      cfg.act_pg1    <= cmd_byte[5:4];
      cfg.read_pg1   <= cmd_byte[7:6];
    end
  end

  // Bank write port; the sequencer wins, so a colliding event is dropped
  always_comb begin
    eng_wr   = 1'b0;
    wr_addr  = rd_addr;
    wr_data  = 32'h0000_0000;
    evt_addr = ctr_addr(evt.chan,
                        evt.chan[1] ? cfg.act_pg1 : cfg.act_pg0,
                        (evt.chan[1] ? cfg.mode_pair1 : cfg.mode_pair0) ?
                        {3'h0, evt.bin[4:0]} : evt.bin);
    if (state == hcc_pkg::ST_INIT) begin
      eng_wr  = 1'b1;
      wr_data = cmd_hold[hcc_pkg::FILL_BIT] ? pattern : 32'h0000_0000;
    end else if (state == hcc_pkg::ST_RD && slot_free && last_byte) begin
      eng_wr  = 1'b1;
    end else if (evt.valid) begin
      wr_addr = evt_addr;
      wr_data = mem[evt_addr] + 32'h0000_0001;
    end
    wr_en = eng_wr || evt.valid;
  end

  // Counter banks, no reset: software initialises them by command
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Lost-event flag, one cycle per lost event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_drop <= 1'b0;
    end else begin
      evt_drop <= evt.valid && eng_wr;
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_arg_take;
    state == hcc_pkg::ST_ARG && take;
  endsequence
  sequence s_start(logic [5:0] op);
    state == hcc_pkg::ST_IDLE && take && cmd_byte[5:0] == op;
  endsequence

  chk_mode_bits: assert property (s_arg_take |=>
    cfg.mode_pair0 == cmd_hold[6] && cfg.mode_pair1 == cmd_hold[7])
    else $error("mode bits not taken from command");
  chk_act_pg0: assert property (s_arg_take |=>
    cfg.act_pg0 == $past(cmd_byte[1:0])) else $error("active page 0 wrong");
  chk_read_pg0: assert property (s_arg_take |=>
    cfg.read_pg0 == $past(cmd_byte[3:2])) else $error("read page 0 wrong");
  chk_act_pg1: assert property (s_arg_take |=>
    cfg.act_pg1 == $past(cmd_byte[5:4])) else $error("active page 1 wrong");
  chk_read_pg1: assert property (s_arg_take |=>
    cfg.read_pg1 == $past(cmd_byte[7:6])) else $error("read page 1 wrong");
  chk_chan_field: assert property (s_start(hcc_pkg::RD256_OP) |=>
    chan == $past(cmd_byte[7:6])) else $error("channel field wrong");
  chk_short_start: assert property (s_start(hcc_pkg::RD32_OP) |=>
    state == hcc_pkg::ST_RD && idx == 8'h1F && byte_sel == 2'h0)
    else $error("short read not at counter 31");
  chk_long_start: assert property (s_start(hcc_pkg::RD256_OP) |=>
    state == hcc_pkg::ST_RD && idx == 8'hFF) else $error("long read start");
  chk_read_clear: assert property (state == hcc_pkg::ST_RD &&
    slot_free && last_byte |-> wr_en && wr_data == 32'h0000_0000 &&
    wr_addr == {cmd_hold[7:6], (cmd_hold[7] ? cfg.read_pg1 : cfg.read_pg0),
    idx}) else $error("counter not cleared after read");
  chk_init_fill: assert property (state == hcc_pkg::ST_INIT |->
    wr_en && wr_data == (cmd_hold[5] ? {12'h000, cmd_hold[7:6],
    (cmd_hold[7] ? cfg.read_pg1 : cfg.read_pg0), idx, 8'h00} :
    32'h0000_0000)) else $error("init fill wrong");
  chk_echo_byte: assert property (state == hcc_pkg::ST_ECHO &&
    slot_free |=> rsp_valid && rsp_byte == cmd_hold &&
    state == hcc_pkg::ST_IDLE) else $error("echo byte wrong");

endmodule

//--- hcc_host.sv
// Host model: takes response bytes with random back-pressure
module hcc_host (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  output logic            rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  integer     seed = 32'hE25F6EC7;
  logic [7:0] q[$];
  // Stalls at random so a slow host is exercised; bytes land in q
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_ready <= 1'b0;
    end else begin
      if (rsp_valid && rsp_ready) q.push_back(rsp_byte);
      rsp_ready <= ($random(seed) & 1) != 0;
    end
  end
endmodule

//--- histogram_counter_commands_tb.sv
// Self-checking bench for the histogram counter command block
module histogram_counter_commands_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic              busy, evt_drop;
  logic [7:0]        cmd_byte, rsp_byte;
  hcc_pkg::hcc_evt_t evt;
  hcc_pkg::hcc_cfg_t cfg, ec;
  integer            seed = 32'hE25F6EC7;
  integer            err_count = 0;
  integer            n_checks = 0;
  logic [31:0]       m [0:4095];
  logic [7:0]        exq[$];

  hcc_core dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_ready(rsp_ready), .evt(evt), .cfg(cfg),
    .busy(busy), .evt_drop(evt_drop));
  hcc_host host (.clk(clk), .rst(rst), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_ready(rsp_ready));

  // Clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Valid stays up across bytes so it is never driven twice in one step
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      cmd_valid <= 1'b1;
      cmd_byte  <= v[8*i+:8];
      @(posedge clk);
      while (cmd_ready !== 1'b1) @(posedge clk);
    end
    cmd_valid <= 1'b0;
  endtask

  // Waits a bounded time, then idles a few cycles to catch extra bytes
  task automatic drain;
    int t;
    t = 0;
    while (host.q.size() < exq.size() && t < 5000) begin
      @(posedge clk);
      t++;
    end
    repeat (4) @(posedge clk);
    chk(host.q.size(), exq.size());
    while (exq.size() > 0 && host.q.size() > 0)
      chk(host.q.pop_front(), exq.pop_front());
    chk(busy, 1'b0);
    host.q.delete();
    exq.delete();
  endtask

  task automatic config_pair(input logic eq);
    logic [7:0] op, ag;
    op = {2'($random(seed)), 6'h05};
    ag = 8'($random(seed));
    if (eq) ag = {ag[5:4], ag[5:4], ag[1:0], ag[1:0]};
    send({ag, op}, 2);
    ec = {op[7], op[6], ag[7:6], ag[5:4], ag[3:2], ag[1:0]};
    exq.push_back(op);
    drain;
    chk(cfg, ec);
  endtask

  task automatic init(input logic [1:0] c, input logic f);
    logic [7:0] op;
    logic [1:0] p;
    op = {c, f, 5'h15};
    p = c[1] ? ec.read_pg1 : ec.read_pg0;
    for (int i = 0; i < 256; i++)
      m[{c, p, 8'(i)}] = f ? {12'h000, c, p, 8'(i), 8'h00} : 32'h0;
    send({8'h00, op}, 1);
    // Events during the fill lose to the bank write and must be flagged
    for (int j = 0; j < 3; j++) begin
      evt <= '{1'b1, 2'($random(seed)), 8'($random(seed))};
      @(posedge clk);
      if (j == 0) chk(busy, 1'b1);
      else chk(evt_drop, 1'b1);
    end
    evt <= '{1'b0, 2'h0, 8'h00};
    @(posedge clk);
    chk(evt_drop, 1'b1);
    exq.push_back(op);
    drain;
  endtask

  task automatic rd(input logic [1:0] c, input logic lng);
    logic [7:0]  op;
    logic [11:0] k;
    op = {c, lng ? 6'h2D : 6'h0D};
    send({8'h00, op}, 1);
    for (int i = lng ? 255 : 31; i >= 0; i--) begin
      k = {c, c[1] ? ec.read_pg1 : ec.read_pg0, 8'(i)};
      exq.push_back(m[k][15:8]);
      exq.push_back(m[k][23:16]);
      exq.push_back(m[k][31:24]);
      m[k] = 32'h0;
    end
    exq.push_back(op);
    drain;
  endtask

  // Enough hits on two bins that counter bits 8 and up change
  task automatic events(input logic [1:0] c);
    logic [7:0]  bn;
    logic [11:0] k;
    repeat (600) begin
      bn = ($random(seed) & 1) ? 8'h20 : 8'h01;
      evt <= '{1'b1, c, bn};
      if (c[1] ? ec.mode_pair1 : ec.mode_pair0) bn = {3'h0, bn[4:0]};
      k = {c, c[1] ? ec.act_pg1 : ec.act_pg0, bn};
      m[k] = m[k] + 32'h1;
      @(posedge clk);
      chk(evt_drop, 1'b0);
    end
    evt <= '{1'b0, 2'h0, 8'h00};
    @(posedge clk);
  endtask

  // Main sequence: every channel, both fills, both reads
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    evt = '{1'b0, 2'h0, 8'h00};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(cfg, 10'h000);
    // An unknown opcode is taken and gets no answer at all
    send(16'h0000, 1);
    drain;
    for (int c = 0; c < 4; c++) begin
      config_pair(1'b0);
      config_pair(1'b1);
      init(2'(c), c[0]);
      rd(2'(c), 1'b1);
      events(2'(c));
      rd(2'(c), 1'b0);
      rd(2'(c), 1'b0);
    end
    test_done;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    test_done;
  end
endmodule
